// *** design/hid_key_pkg.sv ***
package hid_key_pkg;
  // Clock and report pacing
  localparam int CLK_HZ      = 10_000_000;
  localparam int POLL_MS     = 10;
  localparam int POLL_CYCLES = CLK_HZ / 1000 * POLL_MS;
  localparam int REPORT_BYTES = 8;

  // Report identifiers
  localparam logic [7:0] CMD_AUTH        = 8'hA7;
  localparam logic [7:0] CMD_RANDOM      = 8'hA8;
  localparam logic [7:0] CMD_PIN_READ    = 8'h90;
  localparam logic [7:0] CMD_FWID        = 8'h94;
  localparam logic [7:0] CMD_IRQ         = 8'h95;
  localparam logic [7:0] CMD_ANALOG_READ = 8'h96;
  localparam logic [7:0] CMD_PIN_CFG     = 8'h97;
  localparam logic [3:0] CMD_PERSIST_HI  = 4'h8;

  // Pin select codes
  localparam logic [7:0] SEL_PIN_ONE   = 8'h11;
  localparam logic [7:0] SEL_PIN_SEVEN = 8'h17;
  localparam logic [7:0] SEL_PIN_EIGHT = 8'h18;
  localparam logic [7:0] SEL_PIN_NINE  = 8'h19;
  localparam logic [7:0] SEL_PIN_TEN   = 8'h1A;
  localparam int PIN_NINE_IDX = 3;
  localparam int PIN_TEN_IDX  = 4;

  // Pin configuration codes
  localparam logic [2:0] CFG_DRIVE_LOW  = 3'h0;
  localparam logic [2:0] CFG_DRIVE_HIGH = 3'h1;
  localparam logic [2:0] CFG_INPUT      = 3'h2;
  localparam logic [2:0] CFG_IRQ_RISE   = 3'h5;
  localparam logic [2:0] CFG_IRQ_FALL   = 3'h6;
  localparam logic [2:0] CFG_RESET      = CFG_INPUT;
  localparam logic [7:0] IRQ_NAME_NINE  = 8'h09;
  localparam logic [7:0] IRQ_NAME_TEN   = 8'h0A;

  // Cipher
  localparam logic [31:0] XTEA_DELTA  = 32'h9E3779B9;
  localparam int          XTEA_ROUNDS = 32;

  // Identification string, seven characters per report, zero terminated
  localparam logic [55:0] FWID_PART0 = 56'h45524F4359454B;
  localparam logic [55:0] FWID_PART1 = 56'h00302E302E3120;

  // Register byte addresses
  localparam logic [7:0] ADDR_RX_LO  = 8'h00;
  localparam logic [7:0] ADDR_RX_HI  = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_TX_LO  = 8'h10;
  localparam logic [7:0] ADDR_TX_HI  = 8'h14;
  localparam logic [7:0] ADDR_KEY0   = 8'h18;
  localparam logic [7:0] ADDR_KEY3   = 8'h24;

  // Field positions
  localparam int CTRL_SUBMIT  = 0;
  localparam int STAT_TXVALID = 0;
  localparam int STAT_BUSY    = 1;
  localparam int STAT_AUTH    = 2;
  localparam int STAT_REFUSED = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_DECRYPT, ST_ENCRYPT, ST_POST} state_t;
endpackage : hid_key_pkg

// *** design/xtea_core.sv ***
`timescale 1ns/1ps
module xtea_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request
  input  wire logic        start,
  input  wire logic        decrypt,
  input  wire logic [127:0] key,
  input  wire logic [63:0] v_in,
  // Result
  output logic             done,
  output logic [63:0]      v_out
);
  import hid_key_pkg::*;

  localparam logic [31:0] DEC_SUM = XTEA_DELTA * 32'(XTEA_ROUNDS);

  logic [31:0] v0;
  logic [31:0] v1;
  logic [31:0] sum;
  logic [4:0]  round;
  logic        busy;
  logic        mode_dec;
  logic [31:0] e_v0, e_v1, e_sum, d_v0, d_v1, d_sum;

  function automatic logic [31:0] kw(input logic [127:0] k, input logic [1:0] s);
    kw = k[32*s +: 32];
  endfunction : kw

  function automatic logic [31:0] mix(input logic [31:0] v);
    mix = ((v << 4) ^ (v >> 5)) + v;
  endfunction : mix

  // One full round per clock, both halves
  always_comb
  begin
    e_v0  = v0 + (mix(v1) ^ (sum + kw(key, sum[1:0])));
    e_sum = sum + XTEA_DELTA;
    e_v1  = v1 + (mix(e_v0) ^ (e_sum + kw(key, e_sum[12:11])));
    d_v1  = v1 - (mix(v0) ^ (sum + kw(key, sum[12:11])));
    d_sum = sum - XTEA_DELTA;
    d_v0  = v0 - (mix(d_v1) ^ (d_sum + kw(key, d_sum[1:0])));
  end

  // Round sequencer
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (rst)
    begin
      busy     <= 1'b0;
      round    <= 5'h0;
      v0       <= 32'h0;
      v1       <= 32'h0;
      sum      <= 32'h0;
      mode_dec <= 1'b0;
    end
    else if (start && !busy)
    begin
      busy     <= 1'b1;
      round    <= 5'h0;
      mode_dec <= decrypt;
      v0       <= v_in[31:0];
      v1       <= v_in[63:32];
      sum      <= decrypt ? DEC_SUM : 32'h0;
    end
    else if (busy)
    begin
      v0    <= mode_dec ? d_v0 : e_v0;  // R20
      v1    <= mode_dec ? d_v1 : e_v1;
      sum   <= mode_dec ? d_sum : e_sum;
      round <= round + 5'h1;
      if (round == 5'(XTEA_ROUNDS - 1))
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end

  assign v_out = {v1, v0};

  chk_round_count: assert property (@(posedge clk) disable iff (rst) // R20
    (start && !busy) |-> ##32 !done ##1 done)
    else $error("cipher did not finish after exactly 32 rounds");
endmodule : xtea_core

// *** design/hid_key_command_interpreter.sv ***
//Functional notes
// R1 - Reports are eight bytes both ways, released on a 10 ms poll tick.
// R2 - Byte zero selects the command; unused bytes are ignored.
// R3 - Replies echo the command identifier, except challenge and random replies.
// R4 - Host finds the key by codes and a product string feature request.
// R5 - Challenge 0xA7 answers a fresh four-byte random in bytes zero to three.
// R6 - Host appends its random half, encrypts the block, sends it back.
// R7 - Device decrypts; first half mismatch gives an all-zero reply.
// R8 - On match, new device random, host half kept, block encrypted and sent.
// R9 - Host decrypts and checks its own half to finish authentication.
// R10 - Random request 0xA8 answers a four-byte random number.
// R11 - Pin read 0x90 carries one select byte naming one of five pins.
// R12 - Pin read reply echoes the select byte then level 00 or 01.
// R13 - Analog read 0x96 replies with a ten-bit ratio in two bytes.
// R14 - Pin configure 0x97 carries a select byte and a configuration code.
// R15 - Codes: drive low, drive high, input, rising or falling interrupt.
// R16 - Armed edge sends unsolicited 0x95 report naming pin 0x09 or 0x0A.
// R17 - Unsolicited interrupt reports wait while authentication is in progress.
// R18 - Identification 0x94 returns a zero-ended string, seven characters per report.
// R19 - Identifiers 0x80 to 0x8F are refused and change nothing.
// R20 - Cipher is 32-round xTEA, delta 0x9E3779B9, key word zero lowest.
// R21 - Host compares only the low 48 bits of the final block.
// R22 - Authentication state set by the challenge, cleared when its final reply posts.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module hid_key_command_interpreter #(
  parameter int POLL_CYCLES = hid_key_pkg::POLL_CYCLES,
  parameter int NUM_PINS    = 5
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // APB slave
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Random source and analog sample
  input  wire logic [31:0]         rnd_word,
  output logic                     rnd_take,
  input  wire logic [9:0]          adc_value,
  // Virtual pins
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0]      pin_out,
  output logic [NUM_PINS-1:0]      pin_oe,
  // Indication
  output logic                     auth_active
);
  import hid_key_pkg::*;

  localparam int CW = $clog2(POLL_CYCLES + 1);

  state_t      state;
  logic [31:0] rx_lo, rx_hi, tx_lo, tx_hi;
  logic [31:0] key_word [4];
  logic [63:0] stage, eng_in, eng_out;
  logic [31:0] nonce;
  logic [7:0]  echo_id;
  logic        stage_echo, stage_irq, fw_more, auth_end;
  logic        eng_start, eng_dec, eng_done;
  logic        tx_valid, refused, poll_tick;
  logic [CW-1:0] poll_cnt;
  logic [2:0]  cfg [NUM_PINS];
  logic [1:0]  irq_prev, irq_pend, irq_hit;
  logic [3:0]  slot;

  // Command fields
  logic [7:0] cmd, arg1, arg2;
  logic       apb_wr, submit, ack, accept, post_now, irq_take;
  assign cmd  = rx_lo[7:0];  // R2
  assign arg1 = rx_lo[15:8];
  assign arg2 = rx_lo[23:16];
  assign slot = pin_slot(arg1);

  function automatic logic [3:0] pin_slot(input logic [7:0] sel);
    case (sel)
      SEL_PIN_ONE:   pin_slot = 4'h8;
      SEL_PIN_SEVEN: pin_slot = 4'h9;
      SEL_PIN_EIGHT: pin_slot = 4'hA;
      SEL_PIN_NINE:  pin_slot = 4'hB;
      SEL_PIN_TEN:   pin_slot = 4'hC;
      default:       pin_slot = 4'h0;
    endcase
  endfunction : pin_slot

  function automatic logic is_persist(input logic [7:0] id);
    is_persist = (id[7:4] == CMD_PERSIST_HI);
  endfunction : is_persist

  // Bus strobes and handshakes
  assign pready   = 1'b1;
  assign apb_wr   = psel && penable && pwrite;
  assign submit   = apb_wr && (paddr == ADDR_CTRL) && pwdata[CTRL_SUBMIT];
  assign ack      = apb_wr && (paddr == ADDR_STATUS) && pwdata[STAT_TXVALID];
  assign accept   = submit && (state == ST_IDLE);
  assign post_now = (state == ST_POST) && poll_tick && !tx_valid;
  assign irq_take = (state == ST_IDLE) && !accept && (|irq_pend) && !auth_active;  // R17

  // Poll interval divider
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      poll_cnt  <= '0;
      poll_tick <= 1'b0;
    end
    else
    begin
      poll_tick <= (poll_cnt == CW'(POLL_CYCLES - 1));  // R1
      poll_cnt  <= (poll_cnt == CW'(POLL_CYCLES - 1)) ? '0 : poll_cnt + CW'(1);
    end
  end

  // Register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_lo <= 32'h0;
      rx_hi <= 32'h0;
      for (int i = 0; i < 4; i++)
        key_word[i] <= 32'h0;
    end
    else if (apb_wr)
    begin
      if (paddr == ADDR_RX_LO)
        rx_lo <= pwdata;
      if (paddr == ADDR_RX_HI)
        rx_hi <= pwdata;
      for (int i = 0; i < 4; i++)
        if (paddr == ADDR_KEY0 + 8'(4 * i))
          key_word[i] <= pwdata;  // R20
    end
  end

  // Register reads, captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      case (paddr)
        ADDR_RX_LO:  prdata <= rx_lo;
        ADDR_RX_HI:  prdata <= rx_hi;
        ADDR_CTRL:   prdata <= 32'h0;
        ADDR_STATUS: prdata <= {28'h0, refused, auth_active, state != ST_IDLE, tx_valid};
        ADDR_TX_LO:  prdata <= tx_lo;
        ADDR_TX_HI:  prdata <= tx_hi;
        default:     pslverr <= !(paddr >= ADDR_KEY0 && paddr <= ADDR_KEY3 && paddr[1:0] == 2'h0);
      endcase
    end
  end

  // Command sequencer
  always_ff @(posedge clk)
  begin
    eng_start <= 1'b0;
    rnd_take  <= 1'b0;
    if (rst)
    begin
      state       <= ST_IDLE;
      stage       <= 64'h0;
      eng_in      <= 64'h0;
      eng_dec     <= 1'b0;
      nonce       <= 32'h0;
      echo_id     <= 8'h0;
      stage_echo  <= 1'b0;
      stage_irq   <= 1'b0;
      fw_more     <= 1'b0;
      auth_end    <= 1'b0;
      auth_active <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          stage_echo <= 1'b1;
          stage_irq  <= 1'b0;
          echo_id    <= cmd;
          if (accept && auth_active)
          begin
            eng_in     <= {rx_hi, rx_lo};  // R7
            stage_echo <= 1'b0;  // R3
            eng_dec    <= 1'b1;
            eng_start <= 1'b1;
            state     <= ST_DECRYPT;
          end
          else if (accept && cmd == CMD_AUTH)
          begin
            nonce       <= rnd_word;
            rnd_take    <= 1'b1;
            stage       <= {32'h0, rnd_word};  // R5 R3
            stage_echo  <= 1'b0;
            auth_active <= 1'b1;  // R22
            state       <= ST_POST;
          end
          else if (accept && cmd == CMD_RANDOM)
          begin
            rnd_take   <= 1'b1;
            stage      <= {32'h0, rnd_word};  // R10 R3
            stage_echo <= 1'b0;
            state      <= ST_POST;
          end
          else if (accept && cmd == CMD_PIN_READ && slot[3])
          begin
            stage <= {40'h0, 7'h0, pin_in[slot[2:0]], arg1, cmd};  // R11 R12 R3
            state <= ST_POST;
          end
          else if (accept && cmd == CMD_ANALOG_READ)
          begin
            stage <= {40'h0, adc_value[7:0], 6'h0, adc_value[9:8], cmd};  // R13
            state <= ST_POST;
          end
          else if (accept && cmd == CMD_FWID)
          begin
            stage   <= {FWID_PART0, cmd};  // R18
            fw_more <= 1'b1;
            state   <= ST_POST;
          end
          else if (irq_take)
          begin
            stage      <= {48'h0, irq_pend[0] ? IRQ_NAME_NINE : IRQ_NAME_TEN, CMD_IRQ};  // R16
            stage_echo <= 1'b0;
            stage_irq  <= 1'b1;
            state      <= ST_POST;
          end
        end
        ST_DECRYPT:
        begin
          if (eng_done && eng_out[31:0] != nonce)
          begin
            stage    <= 64'h0;  // R7
            auth_end <= 1'b1;
            state    <= ST_POST;
          end
          else if (eng_done)
          begin
            eng_in    <= {eng_out[63:32], rnd_word};  // R8
            rnd_take  <= 1'b1;
            eng_dec   <= 1'b0;
            eng_start <= 1'b1;
            state     <= ST_ENCRYPT;
          end
        end
        ST_ENCRYPT:
        begin
          if (eng_done)
          begin
            stage    <= eng_out;  // R8
            auth_end <= 1'b1;
            state    <= ST_POST;
          end
        end
        ST_POST:
        begin
          if (post_now && fw_more)
          begin
            stage   <= {FWID_PART1, CMD_FWID};  // R18
            fw_more <= 1'b0;
          end
          else if (post_now)
          begin
            state    <= ST_IDLE;
            auth_end <= 1'b0;
            if (auth_end)
              auth_active <= 1'b0;  // R22
          end
        end
      endcase
    end
  end

  // Outbound report slot, a new post wins over a software clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_valid <= 1'b0;
      tx_lo    <= 32'h0;
      tx_hi    <= 32'h0;
    end
    else if (post_now)
    begin
      tx_valid <= 1'b1;  // R1
      tx_lo    <= stage[31:0];
      tx_hi    <= stage[63:32];
    end
    else if (ack)
      tx_valid <= 1'b0;
  end

  // Refused submissions: busy, unknown pin, persistent-setting range
  always_ff @(posedge clk)
  begin
    if (rst)
      refused <= 1'b0;
    else if ((submit && state != ST_IDLE) || (accept && is_persist(cmd))  // R19
             || (accept && !auth_active && (cmd == CMD_PIN_READ || cmd == CMD_PIN_CFG)
                 && !slot[3]))
      refused <= 1'b1;
    else if (apb_wr && paddr == ADDR_STATUS && pwdata[STAT_REFUSED])
      refused <= 1'b0;
  end

  // Pin configuration and drivers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        cfg[i] <= CFG_RESET;
      pin_out <= '0;
      pin_oe  <= '0;
    end
    else if (accept && !auth_active && cmd == CMD_PIN_CFG && slot[3]  // R14
             && (arg2 <= 8'(CFG_INPUT) || arg2 == 8'(CFG_IRQ_RISE)
                 || arg2 == 8'(CFG_IRQ_FALL)))
    begin
      cfg[slot[2:0]]     <= arg2[2:0];  // R15
      pin_out[slot[2:0]] <= (arg2[2:0] == CFG_DRIVE_HIGH);
      pin_oe[slot[2:0]]  <= (arg2[2:0] == CFG_DRIVE_LOW) || (arg2[2:0] == CFG_DRIVE_HIGH);
    end
  end

  // Edge detection on the two interrupt-capable pins
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_irq
      localparam int P = (g == 0) ? PIN_NINE_IDX : PIN_TEN_IDX;
      assign irq_hit[g] = (cfg[P] == CFG_IRQ_RISE && pin_in[P] && !irq_prev[g])
                       || (cfg[P] == CFG_IRQ_FALL && !pin_in[P] && irq_prev[g]);
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          irq_prev[g] <= 1'b0;
          irq_pend[g] <= 1'b0;
        end
        else
        begin
          irq_prev[g] <= pin_in[P];
          if (irq_hit[g])
            irq_pend[g] <= 1'b1;  // R16
          else if (irq_take && (g == 0 || !irq_pend[0]))
            irq_pend[g] <= 1'b0;
        end
      end
    end
  endgenerate

  xtea_core u_cipher (
    .clk     (clk),
    .rst     (rst),
    .start   (eng_start),
    .decrypt (eng_dec),
    .key     ({key_word[3], key_word[2], key_word[1], key_word[0]}),
    .v_in    (eng_in),
    .done    (eng_done),
    .v_out   (eng_out)
  );

  chk_tx_on_tick: assert property (@(posedge clk) disable iff (rst) // R1
    $rose(tx_valid) |-> $past(poll_tick))
    else $error("report released away from a poll tick");
  chk_reply_echo: assert property (@(posedge clk) disable iff (rst) // R3
    (post_now && stage_echo) |=> tx_lo[7:0] == $past(echo_id))
    else $error("reply identifier differs from command");
  chk_auth_start: assert property (@(posedge clk) disable iff (rst) // R22
    (accept && !auth_active && cmd == CMD_AUTH) |=> auth_active && rnd_take
      && stage[31:0] == $past(rnd_word))
    else $error("challenge did not open authentication with a random value");
  chk_irq_held: assert property (@(posedge clk) disable iff (rst) // R17
    (post_now && stage_irq) |-> !auth_active)
    else $error("interrupt report during authentication");
  chk_mismatch_zero: assert property (@(posedge clk) disable iff (rst) // R7
    (state == ST_DECRYPT && eng_done && eng_out[31:0] != nonce) |=> stage == 64'h0
      && state == ST_POST)
    else $error("failed check did not yield a zero reply");
  chk_match_encrypt: assert property (@(posedge clk) disable iff (rst) // R8
    (state == ST_DECRYPT && eng_done && eng_out[31:0] == nonce) |=> state == ST_ENCRYPT
      && eng_in[63:32] == $past(eng_out[63:32]) && eng_start)
    else $error("host half not kept for the final block");
  chk_persist_refused: assert property (@(posedge clk) disable iff (rst) // R19
    (accept && !auth_active && is_persist(cmd)) |=> refused && state == ST_IDLE)
    else $error("persistent-setting identifier not refused");
  chk_drive_high: assert property (@(posedge clk) disable iff (rst) // R15
    (accept && !auth_active && cmd == CMD_PIN_CFG && slot[3] && arg2 == 8'h01)
      |=> pin_oe[$past(slot[2:0])] && pin_out[$past(slot[2:0])])
    else $error("drive-high code did not drive the pin");
  chk_random_take: assert property (@(posedge clk) disable iff (rst) // R10
    (accept && !auth_active && cmd == CMD_RANDOM) |=> rnd_take && !stage_echo)
    else $error("random request did not consume a random word");

  cov_auth_done: cover property (@(posedge clk) disable iff (rst)
    state == ST_ENCRYPT && eng_done);
  cov_fwid_two: cover property (@(posedge clk) disable iff (rst)
    post_now && fw_more);
  cov_irq_post: cover property (@(posedge clk) disable iff (rst)
    post_now && stage_irq);
endmodule : hid_key_command_interpreter

// *** tb/key_side_model.sv ***
`timescale 1ns/1ps
module key_side_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Random source
  input  wire logic        rnd_take,
  output logic [31:0]      rnd_word,
  output logic [31:0]      used_word,
  // Pins
  input  wire logic [4:0]  ext_lvl,
  input  wire logic [4:0]  pin_out,
  input  wire logic [4:0]  pin_oe,
  output logic [4:0]       pin_in
);
  int seed = 34;
  // Source advances once a word is consumed, remembering the word handed out
  always @(posedge clk)
  begin
    if (rst)
      rnd_word <= 32'h5A3C0F11;
    else if (rnd_take)
    begin
      used_word <= rnd_word;
      rnd_word  <= $random(seed);
    end
  end
  // Pin level is the own drive where enabled, otherwise the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : key_side_model

// *** tb/test_hid_key_command_interpreter.sv ***
`timescale 1ns/1ps
module test_hid_key_command_interpreter;
  import hid_key_pkg::*;
  logic         clk = 0;
  logic         rst = 1;
  logic [7:0]   paddr = 0;
  logic         psel = 0;
  logic         penable = 0;
  logic         pwrite = 0;
  logic [31:0]  pwdata = 0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         slverr;
  logic [31:0]  rnd_word;
  logic [31:0]  used_word;
  logic         rnd_take;
  logic [9:0]   adc_value = 0;
  logic [4:0]   ext_lvl = 0;
  logic [4:0]   pin_in;
  logic [4:0]   pin_out;
  logic [4:0]   pin_oe;
  logic         auth_active;
  logic [127:0] key;
  int           err_total = 0;
  int           check_count = 0;
  int           cycles = 0;
  int           seed = 34;
  logic [7:0]   sels [5] = '{SEL_PIN_ONE, SEL_PIN_SEVEN, SEL_PIN_EIGHT, SEL_PIN_NINE, SEL_PIN_TEN};
  logic [2:0]   cfgs [3] = '{CFG_DRIVE_HIGH, CFG_DRIVE_LOW, CFG_INPUT};

  hid_key_command_interpreter #(.POLL_CYCLES(100)) dut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rnd_word(rnd_word), .rnd_take(rnd_take), .adc_value(adc_value), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .auth_active(auth_active));
  key_side_model far (
    .clk(clk), .rst(rst), .rnd_take(rnd_take), .rnd_word(rnd_word), .used_word(used_word),
    .ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  // Clock and hang limit
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; the request stands until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    slverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic submit(input logic [63:0] rep);
    logic [31:0] s;
    apb(1'b1, ADDR_RX_LO, rep[31:0], s);
    apb(1'b1, ADDR_RX_HI, rep[63:32], s);
    apb(1'b1, ADDR_CTRL, 32'h1, s);
  endtask : submit

  // Poll for an outbound report, take it, then release it
  task automatic get_reply(output logic [63:0] r);
    logic [31:0] s;
    int n = 0;
    s = 0;
    while (s[0] !== 1'b1 && n < 300)
    begin
      apb(1'b0, ADDR_STATUS, 32'h0, s);
      n++;
    end
    check("report ready", 64'h1, {63'h0, s[0]});
    apb(1'b0, ADDR_TX_LO, 32'h0, r[31:0]);
    apb(1'b0, ADDR_TX_HI, 32'h0, r[63:32]);
    apb(1'b1, ADDR_STATUS, 32'h1, s);
  endtask : get_reply

  task automatic xchg(input logic [63:0] rep, output logic [63:0] r);
    submit(rep);
    get_reply(r);
  endtask : xchg

  // Reference cipher in its plain 32 round form
  function automatic logic [63:0] xtea(input logic [63:0] v, input logic dec);
    logic [31:0] v0, v1, sum;
    v0 = v[31:0];
    v1 = v[63:32];
    sum = dec ? 32'(XTEA_DELTA * XTEA_ROUNDS) : 32'h0;
    for (int i = 0; i < XTEA_ROUNDS; i++)
      if (!dec)
      begin
        v0 += (((v1 << 4) ^ (v1 >> 5)) + v1) ^ (sum + key[32*sum[1:0] +: 32]);
        sum += XTEA_DELTA;
        v1 += (((v0 << 4) ^ (v0 >> 5)) + v0) ^ (sum + key[32*sum[12:11] +: 32]);
      end
      else
      begin
        v1 -= (((v0 << 4) ^ (v0 >> 5)) + v0) ^ (sum + key[32*sum[12:11] +: 32]);
        sum -= XTEA_DELTA;
        v0 -= (((v1 << 4) ^ (v1 >> 5)) + v1) ^ (sum + key[32*sum[1:0] +: 32]);
      end
    return {v1, v0};
  endfunction : xtea

  // Main sequence
  initial
  begin
    logic [63:0] r;
    logic [63:0] p;
    logic [31:0] s;
    logic [31:0] nonce;
    logic [31:0] host;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0, s);
    check("status after reset", 64'h0, {32'h0, s});
    apb(1'b0, 8'h30, 32'h0, s);
    check("unmapped error", 64'h1, {63'h0, slverr});
    for (int i = 0; i < 4; i++)
    begin
      key[32*i +: 32] = $random(seed);
      apb(1'b1, ADDR_KEY0 + 8'(4*i), key[32*i +: 32], s);
    end
    for (int i = 0; i < 5; i++)
    begin
      ext_lvl <= 5'($random(seed));
      xchg({48'($random(seed)), sels[i], CMD_PIN_READ}, r);
      check("pin read", {47'h0, ext_lvl[i], sels[i], CMD_PIN_READ}, r);
    end
    xchg({32'($random(seed)), 24'($random(seed)), CMD_RANDOM}, r);
    check("random reply", {32'h0, used_word}, r);
    adc_value <= 10'($random(seed));
    xchg({56'($random(seed)), CMD_ANALOG_READ}, r);
    check("analog", {40'h0, adc_value[7:0], 6'h0, adc_value[9:8], CMD_ANALOG_READ}, r);
    for (int i = 8'h80; i < 8'h90; i += 15)
    begin
      submit({56'($random(seed)), 8'(i)});
      apb(1'b0, ADDR_STATUS, 32'h0, s);
      check("refused flag", 64'h8, {60'h0, s[3:0]});
      apb(1'b1, ADDR_STATUS, 32'h8, s);
    end
    submit({48'h0, 8'h12, CMD_PIN_READ});
    apb(1'b0, ADDR_STATUS, 32'h0, s);
    check("bad pin refused", 64'h8, {60'h0, s[3:0]});
    apb(1'b1, ADDR_STATUS, 32'h8, s);
    for (int i = 0; i < 3; i++)
    begin
      submit({40'($random(seed)), 5'h0, cfgs[i], SEL_PIN_ONE, CMD_PIN_CFG});
      apb(1'b0, ADDR_STATUS, 32'h0, s);
      check("pin setup", {62'h0, cfgs[i] != CFG_INPUT, cfgs[i] == CFG_DRIVE_HIGH},
            {62'h0, pin_oe[0], pin_out[0] & pin_oe[0]});
    end
    // Edges arrive during a failed authentication and must wait for its end
    ext_lvl <= 5'b10000;
    submit({40'h0, 5'h0, CFG_IRQ_RISE, SEL_PIN_NINE, CMD_PIN_CFG});
    submit({40'h0, 5'h0, CFG_IRQ_FALL, SEL_PIN_TEN, CMD_PIN_CFG});
    xchg({56'h0, CMD_AUTH}, r);
    nonce = r[31:0];
    check("nonce", {32'h1, used_word}, {31'h0, auth_active, nonce});
    ext_lvl <= 5'b01000;
    host = $random(seed);
    xchg(xtea({host, nonce ^ 32'h1}, 1'b0), r);
    check("bad response", 64'h0, r);
    check("auth cleared", 64'h0, {63'h0, auth_active});
    get_reply(r);
    check("pin nine event", {48'h0, IRQ_NAME_NINE, CMD_IRQ}, r);
    get_reply(r);
    check("pin ten event", {48'h0, IRQ_NAME_TEN, CMD_IRQ}, r);
    // Successful mutual exchange
    xchg({56'($random(seed)), CMD_AUTH}, r);
    nonce = r[31:0];
    xchg(xtea({host, nonce}, 1'b0), r);
    p = xtea(r, 1'b1);
    check("low 48 bits", {16'h0, 48'(xtea({host, used_word}, 1'b0))}, {16'h0, r[47:0]});
    check("host half", {32'h0, host}, {32'h0, p[63:32]});
    check("device half", {32'h0, used_word}, {32'h0, p[31:0]});
    check("auth done", 64'h0, {63'h0, auth_active});
    xchg({56'($random(seed)), CMD_FWID}, r);
    check("ident first", {56'h0, CMD_FWID}, {56'h0, r[7:0]});
    get_reply(r);
    check("ident last", {56'h0, CMD_FWID}, {r[63:56], 48'h0, r[7:0]});
    conclude();
  end
endmodule : test_hid_key_command_interpreter
